/* fpp_flash_model.sv */
`timescale 1ns/100ps
// --------------------------------------------
// flash engine model: busy levels, faults, abort
// --------------------------------------------
module fpp_flash_model
(
  input  wire logic          clk_in,
  input  wire logic [1:0]    mode_in,
  input  wire logic [1:0]    fault_in,
  input  wire logic [3:0]    lat_in,
  input  wire logic          abort_in,
  output fpp_pkg::fpp_flash_t flash_out,
  output logic               done_out
);
  logic [3:0] cnt_r = 4'h0;
  logic       ab_r  = 1'b0;
  initial done_out = 1'b0;
  // an abort is not instant: the erase winds down over lat_in cycles
  always @(posedge clk_in)
  begin
    done_out <= 1'b0;
    if (mode_in != 2'h3)
    begin
      ab_r  <= 1'b0;
      cnt_r <= 4'h0;
    end
    else if (abort_in)
    begin
      ab_r  <= 1'b1;
      cnt_r <= lat_in;
    end
    else if (ab_r && cnt_r != 4'h0)
    begin
      cnt_r    <= cnt_r - 4'h1;
      done_out <= (cnt_r == 4'h1);
    end
  end
  // mode 1 program, 2 bulk erase, 3 sector erase; faults raise the error causes
  assign flash_out = '{mode_in == 2'h1, mode_in == 2'h2,
                       mode_in == 2'h3 && !(ab_r && cnt_r == 4'h0),
                       fault_in[0], fault_in[1]};
endmodule : fpp_flash_model

/* fpp_flash_protect.sv */
`timescale 1ns/100ps
`include "fpp_map.svh"
// What this block does
// - each sector has its own lock bit
// - locks change only via test port or full erase
// - program or erase on locked sector ignored
// - verify on locked sector returns stored data
// - lock status bit i is sector i
// - readout lock shown in bit seven
// - readout lock denies test port access
// - readout lock cleared only by full erase
// - processor keeps flash access under readout lock
// - one write resets flash to read array
// - reset ignored during program or bulk erase
// - reset in read array state aborts sector erase within milliseconds
// - page register read/write at offset E0h
// - page register clears on reset
// - page bits feed decoders and logic array
// - logic arrays get 64-signal input bus
// - turbo cleared gives standby after 70 ns
// - five power bits block control inputs
// - error flag on timeout or one-on-zero
module fpp_flash_protect
(
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire fpp_pkg::fpp_bus_t  bus_in,
  input  wire fpp_pkg::fpp_flash_t flash_in,
  input  wire logic               tap_wr_in,
  input  wire logic [7:0]         tap_lock_in,
  input  wire logic               tap_lock_set_in,
  input  wire logic               chip_erase_done_in,
  input  wire logic               tap_access_in,
  input  wire logic               sec_erase_done_in,
  input  wire logic [2:0]         target_sector_in,
  input  wire logic               prog_req_in,
  input  wire logic               erase_req_in,
  input  wire logic [15:0]        addr_in,
  input  wire logic [2:0]         cntl_in,
  input  wire logic [7:0]         port_b_in,
  input  wire logic [7:0]         port_c_in,
  input  wire logic [2:0]         port_d_in,
  input  wire logic [7:0]         mcell_ab_fb_in,
  input  wire logic [7:0]         mcell_bc_fb_in,
  input  wire logic               ready_busy_in,
  output logic [7:0]              rdata_out,
  output logic [7:0]              page_bits_out,
  output logic [63:0]             array_bus_out,
  output logic                    prog_grant_out,
  output logic                    erase_grant_out,
  output logic                    tap_grant_out,
  output logic                    flash_reset_out,
  output logic                    sect_abort_out,
  output logic                    error_flag_out,
  output logic                    standby_out
);
  // ----------------------------------------------------------------
  // synchronisers for pin inputs
  // ----------------------------------------------------------------
  logic [7:0]  pb_m_r;
  logic [7:0]  pb_s_r;
  logic [7:0]  pc_m_r;
  logic [7:0]  pc_s_r;
  logic [2:0]  pd_m_r;
  logic [2:0]  pd_s_r;

  always_ff @(posedge clk_in)
  begin
    pb_m_r <= port_b_in;
    pb_s_r <= pb_m_r;
    pc_m_r <= port_c_in;
    pc_s_r <= pc_m_r;
    pd_m_r <= port_d_in;
    pd_s_r <= pd_m_r;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]         page_r;
  logic [7:0]         page_nxt;
  logic [7:0]         seclock_r;
  logic [7:0]         seclock_nxt;
  logic               rdlock_r;
  logic               rdlock_nxt;
  logic [7:0]         pwr0_r;
  logic [7:0]         pwr0_nxt;
  logic [7:0]         pwr1_r;
  logic [7:0]         pwr1_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic               cmd_rst;

  assign cmd_rst = bus_in.wr && (bus_in.addr == `FPP_OFF_FLASH_CMD)
                   && (bus_in.wdata == `FPP_CMD_RESET);

  always_comb
  begin
    page_nxt    = page_r;
    seclock_nxt = seclock_r;
    rdlock_nxt  = rdlock_r;
    pwr0_nxt    = pwr0_r;
    pwr1_nxt    = pwr1_r;
    rdata_nxt   = 8'h00;
    if (bus_in.wr)
    begin
      unique case (bus_in.addr)
        `FPP_OFF_PAGE: page_nxt = bus_in.wdata;
        `FPP_OFF_PWR0: pwr0_nxt = bus_in.wdata;
        `FPP_OFF_PWR1: pwr1_nxt = bus_in.wdata;
        default:       page_nxt = page_r; // lock registers not writable
      endcase
    end
    // lock bits only move from the test port side or on full erase
    if (tap_wr_in && !rdlock_r)
      seclock_nxt = tap_lock_in;
    if (chip_erase_done_in)
    begin
      rdlock_nxt  = 1'b0;
      seclock_nxt = 8'h00;
    end
    // a lock set in the erase cycle survives it: fail towards secure
    if (tap_lock_set_in)
      rdlock_nxt = 1'b1;
    if (bus_in.rd)
    begin
      unique case (bus_in.addr)
        `FPP_OFF_PAGE:    rdata_nxt = page_r;
        `FPP_OFF_SECLOCK: rdata_nxt = seclock_r;
        `FPP_OFF_RDLOCK:  rdata_nxt = {rdlock_r, 7'h00};
        `FPP_OFF_PWR0:    rdata_nxt = pwr0_r;
        `FPP_OFF_PWR1:    rdata_nxt = pwr1_r;
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      page_r    <= `FPP_RST_PAGE;
      pwr0_r    <= `FPP_RST_PWR0;
      pwr1_r    <= `FPP_RST_PWR1;
      rdata_r   <= 8'h00;
    end
    else
    begin
      page_r    <= page_nxt;
      pwr0_r    <= pwr0_nxt;
      pwr1_r    <= pwr1_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // lock state is nonvolatile: device reset leaves it alone
  always_ff @(posedge clk_in)
  begin
    seclock_r <= seclock_nxt;
    rdlock_r  <= rdlock_nxt;
  end

  // ----------------------------------------------------------------
  // flash command gating and reset sequencing
  // ----------------------------------------------------------------
  fpp_pkg::fpp_state_t st_r;
  fpp_pkg::fpp_state_t st_nxt;
  logic [19:0]         abort_cnt_r;
  logic [19:0]         abort_cnt_nxt;
  logic                err_r;
  logic                err_nxt;
  logic                pgnt_r;
  logic                pgnt_nxt;
  logic                egnt_r;
  logic                egnt_nxt;
  logic                tgnt_r;
  logic                tgnt_nxt;
  logic                frst_r;
  logic                frst_nxt;
  logic                ab_r;
  logic                ab_nxt;
  logic                locked;

  assign locked = seclock_r[target_sector_in];

  always_comb
  begin
    st_nxt        = st_r;
    abort_cnt_nxt = abort_cnt_r;
    err_nxt       = err_r;
    frst_nxt      = 1'b0;
    ab_nxt        = 1'b0;
    // locked sector: request dropped, array left as is; reads unaffected
    pgnt_nxt      = prog_req_in && !locked;
    egnt_nxt      = erase_req_in && !locked;
    // processor bus never gated by readout lock
    tgnt_nxt      = tap_access_in && !rdlock_r;
    unique case (st_r)
      fpp_pkg::FPP_READ_ARRAY:
      begin
        if (cmd_rst && !flash_in.prog_busy && !flash_in.bulk_busy)
        begin
          frst_nxt = 1'b1;
          err_nxt  = 1'b0;
          if (flash_in.sect_busy)
          begin
            ab_nxt        = 1'b1;
            abort_cnt_nxt = 20'h00000;
            st_nxt        = fpp_pkg::FPP_ABORTING;
          end
        end
        else if (flash_in.algo_timeout || flash_in.prog_one_on_zero)
        begin
          err_nxt = 1'b1;
          st_nxt  = fpp_pkg::FPP_ERROR_HOLD;
        end
      end
      fpp_pkg::FPP_ABORTING:
      begin
        abort_cnt_nxt = abort_cnt_r + 20'h00001;
        if (sec_erase_done_in || (abort_cnt_r == `FPP_ABORT_CYC))
          st_nxt = fpp_pkg::FPP_READ_ARRAY;
      end
      fpp_pkg::FPP_ERROR_HOLD:
      begin
        // flag stays until the processor resets the flash
        if (cmd_rst && !flash_in.prog_busy && !flash_in.bulk_busy)
        begin
          frst_nxt = 1'b1;
          err_nxt  = 1'b0;
          st_nxt   = fpp_pkg::FPP_READ_ARRAY;
        end
      end
      default: st_nxt = fpp_pkg::FPP_READ_ARRAY;
    endcase
    // a fault in the same cycle as a reset command must not be lost
    if (flash_in.algo_timeout || flash_in.prog_one_on_zero)
      err_nxt = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_r        <= fpp_pkg::FPP_READ_ARRAY;
      abort_cnt_r <= 20'h00000;
      err_r       <= 1'b0;
      pgnt_r      <= 1'b0;
      egnt_r      <= 1'b0;
      tgnt_r      <= 1'b0;
      frst_r      <= 1'b0;
      ab_r        <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      abort_cnt_r <= abort_cnt_nxt;
      err_r       <= err_nxt;
      pgnt_r      <= pgnt_nxt;
      egnt_r      <= egnt_nxt;
      tgnt_r      <= tgnt_nxt;
      frst_r      <= frst_nxt;
      ab_r        <= ab_nxt;
    end
  end

  // ----------------------------------------------------------------
  // logic array input bus and power gating
  // ----------------------------------------------------------------
  logic [63:0] arr_r;
  logic [63:0] arr_nxt;
  logic [2:0]  cntl_g;
  logic        rst_g;

  // five blocking bits save power; only safe if the equations skip them
  assign cntl_g = cntl_in & ~{pwr0_r[2], pwr0_r[1], pwr0_r[0]};
  assign rst_g  = rst_in & ~pwr0_r[4];

  always_comb
  begin
    arr_nxt = {addr_in, cntl_g, rst_g, pb_s_r, pc_s_r, pd_s_r,
               page_r, mcell_ab_fb_in, mcell_bc_fb_in,
               ready_busy_in & ~pwr1_r[0]};
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      arr_r <= 64'h0;
    else
      arr_r <= arr_nxt;
  end

  fpp_idle_det u_idle
  (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .turbo_in    (pwr0_r[`FPP_TURBO_BIT]),
    .bus_in      (arr_r),
    .standby_out (standby_out)
  );

  assign rdata_out       = rdata_r;
  assign page_bits_out   = page_r;
  assign array_bus_out   = arr_r;
  assign prog_grant_out  = pgnt_r;
  assign erase_grant_out = egnt_r;
  assign tap_grant_out   = tgnt_r;
  assign flash_reset_out = frst_r;
  assign sect_abort_out  = ab_r;
  assign error_flag_out  = err_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  lock_blocks_prog_a: assert property (prog_req_in && locked |=> !prog_grant_out)
    else $error("program granted on locked sector");
  tap_denied_a: assert property (tap_access_in && rdlock_r |=> !tap_grant_out)
    else $error("test port granted under readout lock");
  busy_reset_a: assert property (cmd_rst && flash_in.prog_busy |=> !flash_reset_out)
    else $error("reset accepted during program");
  reset_pulse_a: assert property (cmd_rst && !flash_in.prog_busy && !flash_in.bulk_busy
                                  && !flash_in.algo_timeout && !flash_in.prog_one_on_zero
                                  |=> flash_reset_out && !error_flag_out)
    else $error("flash reset not issued");
  sect_abort_a: assert property (cmd_rst && flash_in.sect_busy && st_r == fpp_pkg::FPP_READ_ARRAY
                                 && !flash_in.prog_busy && !flash_in.bulk_busy
                                 |=> sect_abort_out)
    else $error("sector erase not aborted");
  page_write_a: assert property (bus_in.wr && bus_in.addr == `FPP_OFF_PAGE
                                 |=> page_bits_out == $past(bus_in.wdata))
    else $error("page register not written");
  lock_ro_a: assert property (!tap_wr_in && !chip_erase_done_in |=> $stable(seclock_r))
    else $error("sector locks changed from bus");
  rdlock_read_a: assert property (bus_in.rd && bus_in.addr == `FPP_OFF_RDLOCK
                                  |=> rdata_out == {$past(rdlock_r), 7'h00})
    else $error("readout lock read wrong");
  err_set_a: assert property (st_r == fpp_pkg::FPP_READ_ARRAY && !cmd_rst
                              && flash_in.algo_timeout |=> error_flag_out)
    else $error("error flag not set");
  reset_page_a: assert property (@(posedge clk_in) disable iff (1'b0)
                                 rst_in |=> page_bits_out == 8'h00)
    else $error("page not cleared");
  abort_cov_c: cover property (st_r == fpp_pkg::FPP_ABORTING);
  err_cov_c: cover property (error_flag_out ##[1:20] flash_reset_out);
  stby_cov_c: cover property (standby_out);
endmodule : fpp_flash_protect

/* fpp_idle_det.sv */
`timescale 1ns/100ps
`include "fpp_map.svh"
// standby detector: counts cycles of unchanged inputs
module fpp_idle_det
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        turbo_in,
  input  wire logic [63:0] bus_in,
  output logic             standby_out
);
  logic [63:0] last_r;
  logic [63:0] last_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic        stby_r;
  logic        stby_nxt;

  always_comb
  begin
    last_nxt = bus_in;
    cnt_nxt  = cnt_r;
    stby_nxt = 1'b0;
    if (turbo_in || (bus_in != last_r))
      cnt_nxt = 5'h00;
    else if (cnt_r != 5'(`FPP_IDLE_CYC))
      cnt_nxt = cnt_r + 5'h01;
    if (!turbo_in && (cnt_nxt == 5'(`FPP_IDLE_CYC)))
      stby_nxt = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      last_r <= 64'h0;
      cnt_r  <= 5'h00;
      stby_r <= 1'b0;
    end
    else
    begin
      last_r <= last_nxt;
      cnt_r  <= cnt_nxt;
      stby_r <= stby_nxt;
    end
  end

  assign standby_out = stby_r;
endmodule : fpp_idle_det

/* fpp_map.svh */
`ifndef FPP_MAP_SVH
`define FPP_MAP_SVH
`define FPP_OFF_PAGE      8'hE0
`define FPP_OFF_SECLOCK   8'hC0
`define FPP_OFF_RDLOCK    8'hC2
`define FPP_OFF_PWR0      8'hB0
`define FPP_OFF_PWR1      8'hB4
`define FPP_OFF_FLASH_CMD 8'h00
`define FPP_RST_PAGE      8'h00
`define FPP_RST_PWR0      8'h00
`define FPP_RST_PWR1      8'h00
`define FPP_CMD_RESET     8'hF0
`define FPP_TURBO_BIT     3
`define FPP_RDLOCK_BIT    7
`define FPP_IDLE_NS       70
`define FPP_CLK_NS        4
`define FPP_IDLE_CYC      ((`FPP_IDLE_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_ABORT_CYC     20'd250000
`endif

/* fpp_pkg.sv */
package fpp_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpp_bus_t;
  typedef struct packed {
    logic       prog_busy;
    logic       bulk_busy;
    logic       sect_busy;
    logic       algo_timeout;
    logic       prog_one_on_zero;
  } fpp_flash_t;
  typedef enum logic [1:0] {
    FPP_READ_ARRAY = 2'b00,
    FPP_ABORTING   = 2'b01,
    FPP_ERROR_HOLD = 2'b10
  } fpp_state_t;
endpackage : fpp_pkg

/* tb.sv */
`timescale 1ns/100ps
module tb;
  // --------------------------------------------
  // signals
  // --------------------------------------------
  logic                clk_in, rst_in, tap_wr_in, tap_lock_set_in, chip_erase_done_in;
  logic                tap_access_in, sec_erase_done_in, prog_req_in, erase_req_in;
  logic                ready_busy_in, prog_grant_out, erase_grant_out, tap_grant_out;
  logic                flash_reset_out, sect_abort_out, error_flag_out, standby_out;
  fpp_pkg::fpp_bus_t   bus_in;
  fpp_pkg::fpp_flash_t flash_in;
  logic [7:0]          tap_lock_in, port_b_in, port_c_in, mcell_ab_fb_in, mcell_bc_fb_in;
  logic [7:0]          rdata_out, page_bits_out, pg, lk;
  logic [2:0]          target_sector_in, cntl_in, port_d_in;
  logic [15:0]         addr_in;
  logic [63:0]         array_bus_out;
  logic [1:0]          mode, fault;
  logic [3:0]          lat;
  logic [31:0]         rnd;
  logic                rd_p1 = 1'b0;
  logic [7:0]          exp_q[$];
  int                  failures, checks_done, i;
  integer              seed;

  fpp_flash_protect uut (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in),
    .flash_in(flash_in), .tap_wr_in(tap_wr_in), .tap_lock_in(tap_lock_in),
    .tap_lock_set_in(tap_lock_set_in), .chip_erase_done_in(chip_erase_done_in),
    .tap_access_in(tap_access_in), .sec_erase_done_in(sec_erase_done_in),
    .target_sector_in(target_sector_in), .prog_req_in(prog_req_in),
    .erase_req_in(erase_req_in), .addr_in(addr_in), .cntl_in(cntl_in),
    .port_b_in(port_b_in), .port_c_in(port_c_in), .port_d_in(port_d_in),
    .mcell_ab_fb_in(mcell_ab_fb_in), .mcell_bc_fb_in(mcell_bc_fb_in),
    .ready_busy_in(ready_busy_in), .rdata_out(rdata_out), .page_bits_out(page_bits_out),
    .array_bus_out(array_bus_out), .prog_grant_out(prog_grant_out),
    .erase_grant_out(erase_grant_out), .tap_grant_out(tap_grant_out),
    .flash_reset_out(flash_reset_out), .sect_abort_out(sect_abort_out),
    .error_flag_out(error_flag_out), .standby_out(standby_out));

  fpp_flash_model partner (.clk_in(clk_in), .mode_in(mode), .fault_in(fault),
    .lat_in(lat), .abort_in(sect_abort_out), .flash_out(flash_in),
    .done_out(sec_erase_done_in));

  // --------------------------------------------
  // tasks
  // --------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // a read notes its expected byte; the monitor compares it a cycle later
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    if (!w)
      exp_q.push_back(d);
    bus_in = '{w, !w, a, d};
  endtask : op

  task automatic idle(input int n);
    @(negedge clk_in);
    bus_in = '0;
    repeat (n - 1) @(negedge clk_in);
  endtask : idle

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk_in)
    rd_p1 <= bus_in.rd;
  always @(negedge clk_in)
    if (rd_p1 === 1'b1)
      chk(rdata_out, exp_q.pop_front());

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  initial
  begin
    #20000;
    failures++;
    end_of_test();
  end

  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial
  begin
    seed = 32'h63bf966b;
    {bus_in, tap_wr_in, tap_lock_set_in, tap_access_in} = '0;
    // locks are not reset: erase them during reset so they start known
    chip_erase_done_in = 1'b1;
    {prog_req_in, erase_req_in, ready_busy_in, tap_lock_in, port_b_in, port_c_in} = '0;
    {mcell_ab_fb_in, mcell_bc_fb_in, target_sector_in, cntl_in, port_d_in, addr_in} = '0;
    {mode, fault, lat} = '0;
    rst_in = 1'b1;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    chip_erase_done_in = 1'b0;
    chk(page_bits_out, 8'h00);
    chk(error_flag_out, 1'b0);
    rnd = $random(seed);
    pg = rnd[7:0];
    op(1'b1, 8'hE0, pg);
    op(1'b0, 8'hE0, pg);
    op(1'b0, 8'h12, 8'h00);
    idle(2);
    chk(page_bits_out, pg);
    rst_in = 1'b1;
    @(negedge clk_in);
    rst_in = 1'b0;
    pg = 8'h00;
    chk(page_bits_out, 8'h00);
    op(1'b0, 8'hE0, 8'h00);
    idle(2);
    $display("page test done");

    chip_erase_done_in = 1'b1;
    @(negedge clk_in);
    chip_erase_done_in = 1'b0;
    lk = rnd[15:8];
    tap_lock_in = lk;
    tap_wr_in = 1'b1;
    @(negedge clk_in);
    tap_wr_in = 1'b0;
    op(1'b0, 8'hC0, lk);
    op(1'b1, 8'hC0, ~lk);
    op(1'b0, 8'hC0, lk);
    op(1'b0, 8'hC2, 8'h00);
    idle(2);
    for (i = 0; i < 8; i++)
    begin
      @(negedge clk_in);
      target_sector_in = i[2:0];
      prog_req_in = 1'b1;
      erase_req_in = i[0];
      @(negedge clk_in);
      chk(prog_grant_out, !lk[i]);
      chk(erase_grant_out, i[0] & !lk[i]);
    end
    {prog_req_in, erase_req_in} = '0;
    $display("sector lock test done");

    tap_access_in = 1'b1;
    idle(2);
    chk(tap_grant_out, 1'b1);
    tap_lock_set_in = 1'b1;
    @(negedge clk_in);
    tap_lock_set_in = 1'b0;
    tap_lock_in = ~lk;
    tap_wr_in = 1'b1;
    @(negedge clk_in);
    tap_wr_in = 1'b0;
    op(1'b0, 8'hC2, 8'h80);
    op(1'b1, 8'hC2, 8'h00);
    op(1'b0, 8'hC2, 8'h80);
    op(1'b0, 8'hC0, lk);
    pg = rnd[23:16];
    op(1'b1, 8'hE0, pg);
    op(1'b0, 8'hE0, pg);
    idle(2);
    chk(tap_grant_out, 1'b0);
    chip_erase_done_in = 1'b1;
    @(negedge clk_in);
    chip_erase_done_in = 1'b0;
    op(1'b0, 8'hC2, 8'h00);
    op(1'b0, 8'hC0, 8'h00);
    idle(2);
    chk(tap_grant_out, 1'b1);
    $display("readout lock test done");

    for (i = 0; i < 4; i++)
    begin
      mode = i[1:0];
      lat = rnd[27:24] | 4'h1;
      op(1'b1, 8'h00, 8'hF0);
      idle(1);
      chk(flash_reset_out, i == 0 || i == 3);
      chk(sect_abort_out, i == 3);
      idle(1);
      chk(flash_reset_out, 1'b0);
      for (int k = 0; k < 40 && i == 3 && sec_erase_done_in !== 1'b1; k++)
        @(negedge clk_in);
      chk(sec_erase_done_in, i == 3);
      mode = 2'h0;
    end
    for (i = 1; i < 3; i++)
    begin
      fault = i[1:0];
      idle(3);
      fault = 2'h0;
      idle(3);
      chk(error_flag_out, 1'b1);
      op(1'b1, 8'h00, 8'hF0);
      idle(2);
      chk(error_flag_out, 1'b0);
    end
    $display("flash reset test done");

    rnd = $random(seed);
    {addr_in, cntl_in, port_d_in, ready_busy_in} = rnd[22:0];
    rnd = $random(seed);
    {port_b_in, port_c_in, mcell_ab_fb_in, mcell_bc_fb_in} = rnd;
    idle(8);
    chk(array_bus_out, {addr_in, cntl_in, 1'b0, port_b_in, port_c_in, port_d_in,
        pg, mcell_ab_fb_in, mcell_bc_fb_in, ready_busy_in});
    op(1'b1, 8'hB0, 8'h17);
    op(1'b1, 8'hB4, 8'h01);
    idle(8);
    chk(array_bus_out, {addr_in, 3'h0, 1'b0, port_b_in, port_c_in, port_d_in,
        pg, mcell_ab_fb_in, mcell_bc_fb_in, 1'b0});
    op(1'b1, 8'hB0, 8'h08);
    op(1'b1, 8'hB4, 8'h00);
    idle(30);
    chk(standby_out, 1'b0);
    op(1'b1, 8'hB0, 8'h00);
    idle(30);
    chk(standby_out, 1'b1);
    addr_in = ~addr_in;
    idle(4);
    chk(standby_out, 1'b0);
    $display("logic array test done");
    chk(exp_q.size(), 0);
    end_of_test();
  end
endmodule : tb
